// ==== rtl/tsr_pkg.sv ====
// Purpose: shared constants and types for the thermocouple scan readout
// Assumes: 20 MHz system clock
// Notes: word offsets index 16-bit scan words on the register port
package tsr_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_NS = 50;
  localparam int unsigned MS_NS = 1_000_000;
  localparam int unsigned MS_CYCLES = MS_NS / CLK_NS;
  localparam int unsigned BLINK_MS = 500;
  localparam int unsigned BLINK_CYCLES = BLINK_MS * MS_CYCLES;
  // ****************************************
  // register map and fields
  // ****************************************
  localparam int unsigned NUM_CH = 5;
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_CH1 = 4'h1;
  localparam logic [3:0] ADDR_CFG = 4'h6;
  localparam int unsigned ST_TYPE_LSB = 0;
  localparam int unsigned ST_PWM_LSB = 3;
  localparam int unsigned ST_BRK_LSB = 8;
  localparam int unsigned CT_SRC_LSB = 0;
  localparam int unsigned CT_DIS_LSB = 8;
  localparam int unsigned CFG_SCALE_BIT = 0;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] CFG_RST = 16'h0000;
  localparam logic [12:0] PWM_RST = 13'h0000;
  localparam logic [15:0] VAL_RST = 16'h0000;
  localparam logic [15:0] BREAK_VALUE = 16'hFFFF;
  localparam int unsigned RAW_W = 15;
  localparam int unsigned PWM_W = 13;
  localparam int unsigned SCL_SHIFT = 15;
  localparam int unsigned SCL_ROUND = 16384;
  // ****************************************
  // sensor types: status code and scaled span (x10 degrees)
  // ****************************************
  localparam logic [2:0] TC_J = 3'h0, TC_K = 3'h1, TC_T = 3'h2, TC_E = 3'h3;
  localparam logic [2:0] TC_R = 3'h4, TC_S = 3'h5, TC_B = 3'h6, TC_NONE = 3'h7;
  localparam int SCL_LO_J = -500, SCL_HI_J = 7500;
  localparam int SCL_LO_R = 1000, SCL_HI_R = 17000;
  localparam int SCL_LO_T = -1000, SCL_HI_T = 4000;
  localparam int SCL_LO_B = 2000, SCL_HI_B = 18000;
  localparam int SCL_LO_K = 0, SCL_HI_K = 12000;
  localparam int SCL_LO_S = 1000, SCL_HI_S = 17000;
  localparam int SCL_LO_E = 0, SCL_HI_E = 10000;
  typedef enum logic [2:0] {
    SW_J = 3'h0, SW_R = 3'h1, SW_T = 3'h2, SW_B = 3'h3,
    SW_K = 3'h4, SW_S = 3'h5, SW_E = 3'h6, SW_BAD = 3'h7
  } tsr_switch_t;
  typedef enum logic [0:0] {SCAN_PICK = 1'b0, SCAN_WAIT = 1'b1} tsr_scan_t;
  typedef struct packed {
    logic brk;
    logic [14:0] raw;
  } tsr_sample_t;
endpackage : tsr_pkg

// ==== rtl/tsr_readout.sv ====
// Purpose: five channel thermocouple scan, scaling, break detect, lamps, pwm
// Assumes: converter front end answers each start with one done pulse
// Notes: register port words are 16 bits wide
// Functional notes
// R1: error lamp lit while any wire broken
// R2: output lamp lit exactly while pwm on
// R3: scan enabled channels, raw 0 to 32767
// R4: scaled mode reports ten times degrees
// R5: disabled channels skipped, shorter cycle
// R6: disabled channel keeps last converted value
// R7: open wire sets flag, value FFFF
// R8: pwm from loop controller or manual value
// R9: three switches select sensor type
// R10: fourth switch selects signed or unsigned
// R11: one type and format for all
// R12: invalid configuration blinks activity lamp slowly
// R13: status word type, pwm, break fields
// R14: signed two's complement or unsigned word
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module tsr_readout
  import tsr_pkg::*;
#(
  parameter int unsigned MS_DIV = MS_CYCLES,
  parameter int unsigned BLINK_DIV = BLINK_CYCLES
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  input wire logic type_switch_a_i,
  input wire logic type_switch_b_i,
  input wire logic type_switch_c_i,
  input wire logic sign_switch_i,
  input wire logic [4:0] loop_ctrl_on_i,
  output logic conv_start_o,
  output logic [2:0] conv_ch_o,
  input wire logic conv_done_i,
  input wire tsr_sample_t conv_data_i,
  output logic [4:0] pwm_o,
  output logic [4:0] out_lamp_o,
  output logic err_lamp_o,
  output logic activity_lamp_o
);
  if (MS_DIV < 2 || BLINK_DIV < 2) begin : g_chk
    $error("tsr_readout: dividers must be at least 2");
  end

  // ****************************************
  // configuration
  // ****************************************
  tsr_switch_t sw;
  logic [2:0] type_code;
  logic cfg_bad;
  logic [15:0] ctrl_r;
  logic [15:0] cfg_r;
  logic [12:0] pwm_val_r [NUM_CH];
  logic [15:0] val_r [NUM_CH];
  logic [4:0] brk_r;
  logic [4:0] pwm_r;
  logic [4:0] dis;
  logic [4:0] src;

  assign sw = tsr_switch_t'({type_switch_a_i, type_switch_b_i, type_switch_c_i});
  assign cfg_bad = (sw == SW_BAD);
  assign dis = ctrl_r[CT_DIS_LSB +: NUM_CH];
  assign src = ctrl_r[CT_SRC_LSB +: NUM_CH];

  // switch order differs from the status code order
  always_comb begin
    case (sw) // [R9] [R11]
      SW_J: type_code = TC_J;
      SW_R: type_code = TC_R;
      SW_T: type_code = TC_T;
      SW_B: type_code = TC_B;
      SW_K: type_code = TC_K;
      SW_S: type_code = TC_S;
      SW_E: type_code = TC_E;
      default: type_code = TC_NONE;
    endcase
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_r <= CTRL_RST;
      cfg_r <= CFG_RST;
    end else if (reg_wr_i) begin
      if (reg_addr_i == ADDR_CTRL) ctrl_r <= reg_wdata_i;
      if (reg_addr_i == ADDR_CFG) cfg_r <= reg_wdata_i;
    end
  end

  for (genvar i = 0; i < NUM_CH; i++) begin : g_pwv
    always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) pwm_val_r[i] <= PWM_RST;
      else if (reg_wr_i && reg_addr_i == ADDR_CH1 + 4'(i))
        pwm_val_r[i] <= reg_wdata_i[PWM_W-1:0];
    end
  end

  // ****************************************
  // scaling of one sample
  // ****************************************
  int lo;
  int hi;
  logic [15:0] raw_adj;
  logic [31:0] prod;
  int scaled;
  logic [15:0] result;

  always_comb begin
    case (type_code)
      TC_J: begin lo = SCL_LO_J; hi = SCL_HI_J; end
      TC_R: begin lo = SCL_LO_R; hi = SCL_HI_R; end
      TC_T: begin lo = SCL_LO_T; hi = SCL_HI_T; end
      TC_B: begin lo = SCL_LO_B; hi = SCL_HI_B; end
      TC_K: begin lo = SCL_LO_K; hi = SCL_HI_K; end
      TC_S: begin lo = SCL_LO_S; hi = SCL_HI_S; end
      TC_E: begin lo = SCL_LO_E; hi = SCL_HI_E; end
      default: begin lo = 0; hi = 0; end
    endcase
    // full scale 32767 maps to hi exactly, mid scale rounds to nearest
    raw_adj = {1'b0, conv_data_i.raw} + 16'(conv_data_i.raw[RAW_W-1]);
    prod = (32'(raw_adj) * 32'(hi - lo) + 32'(SCL_ROUND)) >> SCL_SHIFT;
    scaled = lo + int'(prod); // [R4]
    if (!sign_switch_i && lo < 0) scaled = scaled - lo; // [R10] [R14]
    if (conv_data_i.brk) result = BREAK_VALUE; // [R7]
    else if (cfg_r[CFG_SCALE_BIT]) result = scaled[15:0]; // [R14]
    else result = {1'b0, conv_data_i.raw}; // [R3]
  end

  // ****************************************
  // channel scan
  // ****************************************
  tsr_scan_t state_r;
  logic [2:0] next_ch;
  logic any_en;

  always_comb begin
    logic [2:0] c;
    c = conv_ch_o;
    next_ch = conv_ch_o;
    any_en = 1'b0;
    for (int k = 0; k < NUM_CH; k++) begin
      c = (c == 3'(NUM_CH - 1)) ? 3'h0 : c + 3'h1;
      if (!any_en && !dis[c]) begin // [R5]
        next_ch = c;
        any_en = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r <= SCAN_PICK;
      conv_start_o <= 1'b0;
      conv_ch_o <= 3'(NUM_CH - 1);
    end else begin
      conv_start_o <= 1'b0;
      case (state_r)
        SCAN_PICK: if (any_en && !cfg_bad) begin // [R3] [R5]
          conv_ch_o <= next_ch;
          conv_start_o <= 1'b1;
          state_r <= SCAN_WAIT;
        end
        SCAN_WAIT: if (conv_done_i) state_r <= SCAN_PICK;
        default: state_r <= SCAN_PICK;
      endcase
    end
  end

  // disabled channels are never started, so their word stays put
  for (genvar i = 0; i < NUM_CH; i++) begin : g_val
    logic hit;
    assign hit = state_r == SCAN_WAIT && conv_done_i && conv_ch_o == 3'(i);
    always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        val_r[i] <= VAL_RST;
        brk_r[i] <= 1'b0;
      end else if (hit) begin
        val_r[i] <= result; // [R6] [R7]
        brk_r[i] <= conv_data_i.brk; // [R7]
      end
    end
  end

  // ****************************************
  // pwm outputs
  // ****************************************
  logic [$clog2(MS_DIV)-1:0] ms_cnt_r;
  logic ms_tick_r;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ms_cnt_r <= '0;
      ms_tick_r <= 1'b0;
    end else begin
      ms_tick_r <= (ms_cnt_r == ($clog2(MS_DIV))'(MS_DIV - 1));
      if (ms_cnt_r == ($clog2(MS_DIV))'(MS_DIV - 1)) ms_cnt_r <= '0;
      else ms_cnt_r <= ms_cnt_r + 1'b1;
    end
  end

  // manual value is the time in ms between toggles; zero holds it off
  for (genvar i = 0; i < NUM_CH; i++) begin : g_pwm
    logic [12:0] tcnt_r;
    logic auto;
    assign auto = src[i] && !brk_r[i];
    always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        pwm_r[i] <= 1'b0;
        tcnt_r <= '0;
      end else if (auto) begin
        pwm_r[i] <= loop_ctrl_on_i[i]; // [R8]
        tcnt_r <= '0;
      end else if (pwm_val_r[i] == PWM_RST) begin
        pwm_r[i] <= 1'b0;
        tcnt_r <= '0;
      end else if (ms_tick_r) begin
        if (tcnt_r + 13'h1 >= pwm_val_r[i]) begin
          pwm_r[i] <= !pwm_r[i]; // [R8]
          tcnt_r <= '0;
        end else tcnt_r <= tcnt_r + 13'h1;
      end
    end
  end

  assign pwm_o = pwm_r;
  assign out_lamp_o = pwm_r; // [R2]

  // ****************************************
  // lamps
  // ****************************************
  logic [$clog2(BLINK_DIV)-1:0] blink_cnt_r;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) err_lamp_o <= 1'b0;
    else err_lamp_o <= |brk_r; // [R1]
  end

  // steady while the switch setting is usable
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      blink_cnt_r <= '0;
      activity_lamp_o <= 1'b0;
    end else if (!cfg_bad) begin
      blink_cnt_r <= '0;
      activity_lamp_o <= 1'b1;
    end else if (blink_cnt_r == ($clog2(BLINK_DIV))'(BLINK_DIV - 1)) begin
      blink_cnt_r <= '0;
      activity_lamp_o <= !activity_lamp_o; // [R12]
    end else blink_cnt_r <= blink_cnt_r + 1'b1;
  end

  // ****************************************
  // register read
  // ****************************************
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) reg_rdata_o <= '0;
    else if (!reg_rd_i) reg_rdata_o <= '0;
    else if (reg_addr_i == ADDR_STATUS)
      reg_rdata_o <= {3'h0, brk_r, pwm_r, type_code}; // [R13]
    else if (reg_addr_i >= ADDR_CH1 && reg_addr_i < ADDR_CH1 + 4'(NUM_CH))
      reg_rdata_o <= val_r[3'(reg_addr_i - ADDR_CH1)];
    else if (reg_addr_i == ADDR_CFG) reg_rdata_o <= cfg_r;
    else reg_rdata_o <= '0;
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  err_lamp_track_a: assert property (err_lamp_o == $past(|brk_r)) // [R1]
    else $error("error lamp does not follow break flags");
  out_lamp_pwm_a: assert property (out_lamp_o == pwm_o) // [R2]
    else $error("output lamp differs from pwm state");
  break_value_a: assert property (state_r == SCAN_WAIT && conv_done_i
    && conv_data_i.brk |=> val_r[conv_ch_o] == BREAK_VALUE && brk_r[conv_ch_o]) // [R7]
    else $error("break did not force value");
  skip_disabled_a: assert property (conv_start_o // [R5]
    |-> ($past(dis) & (5'h01 << conv_ch_o)) == 5'h00)
    else $error("disabled channel was started");
  hold_disabled_a: assert property (dis[1] && $past(dis[1]) && state_r == SCAN_PICK
    |=> $stable(val_r[1])) // [R6]
    else $error("disabled channel value changed");
  raw_range_a: assert property (state_r == SCAN_WAIT && conv_done_i && !conv_data_i.brk
    && !cfg_r[CFG_SCALE_BIT] |=> !val_r[conv_ch_o][15]) // [R3]
    else $error("raw value out of range");
  status_word_a: assert property (reg_rd_i && reg_addr_i == ADDR_STATUS
    |=> reg_rdata_o[7:0] == {$past(pwm_r), $past(type_code)}
    && reg_rdata_o[12:8] == $past(brk_r)) // [R13]
    else $error("status word fields wrong");
  bad_cfg_idle_a: assert property (cfg_bad |=> !conv_start_o) // [R12]
    else $error("scan started with invalid switches");
  type_map_a: assert property (sw == SW_K |-> type_code == TC_K) // [R9]
    else $error("switch to type code mapping wrong");
  manual_off_a: assert property (!src[1] && pwm_val_r[1] == PWM_RST
    |=> !pwm_o[1]) // [R8]
    else $error("manual zero value did not hold output off");
endmodule : tsr_readout
`default_nettype wire

// ==== dv/tsr_conv_model.sv ====
// Purpose: converter front end model, one done pulse per start
// Assumes: the readout waits for each done before the next start
// Notes: data lines carry junk outside the done cycle
`timescale 1ns/1ns
`default_nettype none
module tsr_conv_model
  import tsr_pkg::*;
#(
  parameter int unsigned DELAY = 3
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic conv_start_i,
  input wire logic [2:0] conv_ch_i,
  input wire tsr_sample_t smp_i [NUM_CH],
  output logic conv_done_o,
  output tsr_sample_t conv_data_o,
  output int unsigned done_cnt_o
);
  int unsigned wait_r;
  logic [2:0] ch_r;
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wait_r <= 0;
      ch_r <= 3'h0;
      conv_done_o <= 1'b0;
      conv_data_o <= '0;
      done_cnt_o <= 0;
    end else begin
      conv_done_o <= 1'b0;
      // inverted junk so a sample one cycle late can never match
      conv_data_o <= ~conv_data_o;
      if (conv_start_i) begin
        wait_r <= DELAY;
        ch_r <= conv_ch_i;
      end else if (wait_r == 1) begin
        wait_r <= 0;
        conv_done_o <= 1'b1;
        conv_data_o <= smp_i[ch_r];
        done_cnt_o <= done_cnt_o + 1;
      end else if (wait_r != 0) begin
        wait_r <= wait_r - 1;
      end
    end
  end
endmodule : tsr_conv_model
`default_nettype wire

// ==== dv/tsr_readout_tb_top.sv ====
// Purpose: self-checking bench for the thermocouple scan readout
// Assumes: short ms and blink divisors, converter model answers in 3 cycles
// Notes: register port driven as a plain strobe bus
`timescale 1ns/1ns
`default_nettype none
module tsr_readout_tb_top
  import tsr_pkg::*;
;
  localparam logic [3:0] T_SW [8] = '{4'h1, 4'h0, 4'h4, 4'h9, 4'h7, 4'hD, 4'h3, 4'hB};
  localparam logic [14:0] T_RAW [8] = '{15'h0000, 15'h7FFF, 15'h7FFF, 15'h3FFF,
    15'h7FFF, 15'h3FFF, 15'h0000, 15'h7FFF};
  localparam logic [15:0] T_EXP [8] = '{16'hFE0C, 16'h1F40, 16'h1388, 16'h1770,
    16'h4650, 16'h1388, 16'h03E8, 16'h4268};
  localparam logic [2:0] T_CODE [8] = '{3'h0, 3'h0, 3'h2, 3'h1, 3'h6, 3'h3, 3'h4, 3'h5};
  logic clk, rst_n, reg_wr, reg_rd, start, done, err, act;
  logic [3:0] addr, sw;
  logic [15:0] wdata, rdata;
  logic [2:0] ch;
  logic [4:0] loop_on, pwm, lamp;
  logic p;
  tsr_sample_t data;
  tsr_sample_t smp [NUM_CH];
  int unsigned done_cnt, n0;
  int fails = 0;
  int cmp_count = 0;
  int ch2_starts = 0;

  tsr_readout #(.MS_DIV(4), .BLINK_DIV(8)) tsr_readout_inst (
    .clock_i(clk), .arst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata),
    .type_switch_a_i(sw[3]), .type_switch_b_i(sw[2]), .type_switch_c_i(sw[1]),
    .sign_switch_i(sw[0]), .loop_ctrl_on_i(loop_on), .conv_start_o(start),
    .conv_ch_o(ch), .conv_done_i(done), .conv_data_i(data), .pwm_o(pwm),
    .out_lamp_o(lamp), .err_lamp_o(err), .activity_lamp_o(act));
  tsr_conv_model #(.DELAY(3)) tsr_conv_model_inst (
    .clock_i(clk), .arst_n_i(rst_n), .conv_start_i(start), .conv_ch_i(ch),
    .smp_i(smp), .conv_done_o(done), .conv_data_o(data), .done_cnt_o(done_cnt));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    if (start && ch == 3'h1) ch2_starts++;
  end
  // ****************************************
  // access and check tasks
  // ****************************************
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd_chk(input string name, input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #10;
    chk(name, exp, rdata);
  endtask : rd_chk
  task automatic wait_conv(input int unsigned n);
    int unsigned goal;
    int k;
    goal = done_cnt + n;
    k = 0;
    while (done_cnt < goal && k < 2000) begin
      @(posedge clk);
      k++;
    end
    chk("conversions", 16'h0001, {15'h0000, done_cnt >= goal});
  endtask : wait_conv
  task automatic set_raw(input logic brk, input logic [14:0] raw);
    @(posedge clk);
    for (int i = 0; i < NUM_CH; i++) smp[i] <= '{brk: brk, raw: raw - 15'(i)};
  endtask : set_raw
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict
  initial begin
    #(50 * 30000);
    fails++;
    $display("Error watchdog expected finish seen timeout");
    print_verdict();
  end
  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    {rst_n, reg_wr, reg_rd, addr, wdata, loop_on} = '0;
    sw = 4'h1;
    for (int i = 0; i < NUM_CH; i++) smp[i] = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    set_raw(1'b0, 15'h7FFF);
    wait_conv(10);
    chk("activity_lamp", 16'h0001, {15'h0000, act});
    rd_chk("status", ADDR_STATUS, 16'h0000);
    rd_chk("config", ADDR_CFG, CFG_RST);
    for (int i = 0; i < NUM_CH; i++) rd_chk("raw", ADDR_CH1 + 4'(i), 16'h7FFF - 16'(i));
    $display("test raw done");
    @(posedge clk);
    smp[2] <= '{brk: 1'b1, raw: 15'h0123};
    wait_conv(10);
    rd_chk("break_value", 4'h3, BREAK_VALUE);
    rd_chk("status", ADDR_STATUS, 16'h0400);
    wait_conv(5);
    chk("error_lamp", 16'h0001, {15'h0000, err});
    set_raw(1'b0, 15'h7FFF);
    wait_conv(10);
    chk("error_lamp", 16'h0000, {15'h0000, err});
    $display("test break done");
    wr(ADDR_CTRL, 16'h0200);
    wait_conv(2);
    n0 = ch2_starts;
    set_raw(1'b0, 15'h0100);
    wait_conv(10);
    chk("skipped_starts", 16'(n0), 16'(ch2_starts));
    rd_chk("held_value", 4'h2, 16'h7FFE);
    rd_chk("live_value", 4'h3, 16'h00FE);
    wr(ADDR_CTRL, 16'h0000);
    $display("test disable done");
    wr(ADDR_CFG, 16'h0001);
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      sw <= T_SW[k];
      for (int i = 0; i < NUM_CH; i++) smp[i] <= '{brk: 1'b0, raw: T_RAW[k]};
      wait_conv(10);
      rd_chk("scaled_ch1", ADDR_CH1, T_EXP[k]);
      rd_chk("scaled_ch5", 4'h5, T_EXP[k]);
      rd_chk("type_code", ADDR_STATUS, {13'h0000, T_CODE[k]});
    end
    wr(ADDR_CFG, 16'h0000);
    $display("test scaled done");
    @(posedge clk);
    sw <= 4'hF;
    repeat (20) @(posedge clk);
    #10 p = act;
    repeat (8) @(posedge clk);
    #10 chk("blink", {15'h0000, ~p}, {15'h0000, act});
    rd_chk("bad_type", ADDR_STATUS, 16'h0007);
    @(posedge clk);
    sw <= 4'h1;
    $display("test invalid done");
    wr(ADDR_CTRL, 16'h0001);
    @(posedge clk);
    loop_on <= 5'h1F;
    repeat (2) @(posedge clk);
    #10 chk("pwm_loop", 16'h0001, {11'h000, pwm});
    chk("out_lamp", 16'h0001, {11'h000, lamp});
    rd_chk("status", ADDR_STATUS, 16'h0008);
    wr(4'h2, 16'h0002);
    repeat (20) @(posedge clk);
    #10 p = pwm[1];
    repeat (8) @(posedge clk);
    #10 chk("pwm_manual", {15'h0000, ~p}, {15'h0000, pwm[1]});
    chk("out_lamp", {15'h0000, ~p}, {15'h0000, lamp[1]});
    $display("test pwm done");
    print_verdict();
  end
endmodule : tsr_readout_tb_top
`default_nettype wire
